//--- hw/pport_pkg.sv
// constants, register map and field layout of the parallel port
// assumes a 32-bit register port with word offsets as printed
package pport_pkg;
    localparam logic [15:0] OFF_CONTROL = 16'he000;
    localparam logic [15:0] OFF_MODE = 16'he010;
    localparam logic [15:0] OFF_ADDRESS = 16'he020;
    localparam logic [15:0] OFF_DATA_OUT = 16'he030;
    localparam logic [15:0] OFF_DATA_IN = 16'he040;
    localparam logic [15:0] OFF_PIN_ENABLE = 16'he050;
    localparam logic [15:0] OFF_STATUS = 16'he060;
    // reserved bits are masked on write
    localparam logic [15:0] CONTROL_MASK = 16'hbffb;
    localparam logic [15:0] MODE_MASK = 16'h7fff;
    localparam logic [15:0] STATUS_RESET = 16'h008e;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    // control fields
    localparam int ON_BIT = 15;
    localparam int IDLE_BIT = 13;
    localparam int MUX_LSB = 11;
    localparam int WREN_BIT = 9;
    localparam int RDEN_BIT = 8;
    localparam int CSF_LSB = 6;
    localparam int ALP_BIT = 5;
    localparam int SELECT_TWO_POLARITY_BIT = 4;
    localparam int SELECT_ONE_POLARITY_BIT = 3;
    localparam int WRSP_BIT = 1;
    localparam int RDSP_BIT = 0;
    // mode fields
    localparam int BUSY_BIT = 15;
    localparam int IRQ_MODE_LSB = 13;
    localparam int ADDR_STEP_MODE_LSB = 11;
    localparam int WIDE_BIT = 10;
    localparam int PMODE_LSB = 8;
    localparam int SETUP_LSB = 6;
    localparam int STROBE_LSB = 2;
    localparam int HOLD_LSB = 0;
    localparam int PERIPH_CLK_NS = 5;
    localparam int CLK_NS = 5;
    localparam int CYC_PER_WAIT = (PERIPH_CLK_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_SETUP = 5'b00100,
        ST_STROBE = 5'b01000,
        ST_HOLD = 5'b10000
    } cyc_state_type;
endpackage

//--- hw/pport_cfg_if.sv
// configuration and cycle handshake between regs and sequencer
// assumes one clock domain
`timescale 1ns/1ps
interface pport_cfg_if;
    logic start;
    logic is_write;
    logic busy;
    logic done;
    logic [3:0] strobe_wait;
    logic [1:0] setup_wait;
    logic [1:0] hold_wait;
    logic mux_addr;
    logic [2:0] phase;
    modport ctl (output start, output is_write, output strobe_wait, output setup_wait,
        output hold_wait, output mux_addr, input busy, input done, input phase);
    modport seq (input start, input is_write, input strobe_wait, input setup_wait,
        input hold_wait, input mux_addr, output busy, output done, output phase);
endinterface

//--- hw/pport_seq.sv
// master cycle sequencer: address, setup, strobe, hold phases
// assumes start only while not busy
`timescale 1ns/1ps
module pport_seq
    import pport_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    pport_cfg_if.seq cfg
);
    typedef struct packed {
        cyc_state_type st;
        logic [4:0] cnt;
        logic wr;
    } seq_state_type;
    seq_state_type s_r, s_nxt;
    logic [4:0] setup_len, strobe_len, hold_len;
    always_comb
    begin
        // default waits when strobe wait is zero
        if (cfg.strobe_wait == 4'h0) // RULE23
        begin
            setup_len = 5'd1;
            hold_len = s_r.wr ? 5'd1 : 5'd0;
        end
        else
        begin
            setup_len = 5'(cfg.setup_wait) + 5'd1; // RULE20
            hold_len = 5'(cfg.hold_wait) + (s_r.wr ? 5'd1 : 5'd0); // RULE22
        end
        strobe_len = 5'(cfg.strobe_wait) + 5'd1; // RULE21
    end
    always_comb
    begin
        s_nxt = s_r;
        cfg.done = 1'b0;
        case (s_r.st)
            ST_IDLE:
            begin
                if (cfg.start)
                begin
                    s_nxt.wr = cfg.is_write;
                    s_nxt.cnt = 5'd1;
                    s_nxt.st = cfg.mux_addr ? ST_ADDR : ST_SETUP;
                end
            end
            ST_ADDR:
            begin
                if (s_r.cnt >= setup_len)
                begin
                    s_nxt.cnt = 5'd1;
                    s_nxt.st = ST_SETUP;
                end
                else
                    s_nxt.cnt = s_r.cnt + 5'd1;
            end
            ST_SETUP:
            begin
                if (s_r.cnt >= setup_len)
                begin
                    s_nxt.cnt = 5'd1;
                    s_nxt.st = ST_STROBE;
                end
                else
                    s_nxt.cnt = s_r.cnt + 5'd1;
            end
            ST_STROBE:
            begin
                if (s_r.cnt >= strobe_len)
                begin
                    s_nxt.cnt = 5'd1;
                    if (hold_len == 5'd0)
                    begin
                        s_nxt.st = ST_IDLE;
                        cfg.done = 1'b1;
                    end
                    else
                        s_nxt.st = ST_HOLD;
                end
                else
                    s_nxt.cnt = s_r.cnt + 5'd1;
            end
            ST_HOLD:
            begin
                if (s_r.cnt >= hold_len)
                begin
                    s_nxt.st = ST_IDLE;
                    cfg.done = 1'b1;
                end
                else
                    s_nxt.cnt = s_r.cnt + 5'd1;
            end
            default:
                s_nxt.st = ST_IDLE;
        endcase
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_r <= '{st: ST_IDLE, cnt: 5'd0, wr: 1'b0};
        else
            s_r <= s_nxt;
    end
    assign cfg.busy = (s_r.st != ST_IDLE); // RULE10
    assign cfg.phase = {s_r.st == ST_ADDR, s_r.st == ST_STROBE, s_r.st == ST_HOLD};

    chk_strobe_len: assert property (@(posedge clk) disable iff (rst) // RULE21
        (s_r.st == ST_STROBE && s_r.cnt < strobe_len) |=> (s_r.st == ST_STROBE))
        else $error("strobe phase broken");
    chk_done_idle: assert property (@(posedge clk) disable iff (rst) // RULE10
        cfg.done |=> !cfg.busy)
        else $error("busy after done");
endmodule

//--- hw/parallel_master_slave_port.sv
// top of the parallel port: registers, pin control, slave buffers
// assumes register port strobes one cycle, never both at once
//
// What this block does
// RULE1: enable bit cleared blocks all bus access
// RULE2: stop-in-idle halts port during device idle
// RULE3: mux select places address on data pins
// RULE4: write strobe pin enable owns that pin
// RULE5: read strobe pin enable owns that pin
// RULE6: select function makes pins selects or address
// RULE7: latch polarity sets both latch strobes
// RULE8: select polarity bits set select levels
// RULE9: polarity and function ignored on address pins
// RULE10: busy flag set during master bus cycle
// RULE11: irq mode one interrupts each cycle end
// RULE12: irq mode two interrupts on buffer three
// RULE13: step mode increments or decrements address
// RULE14: step mode three auto-increments slave buffers; code steps only the unused wptr/rptr, and in mode zero slv_idx stays 00
// RULE15: width bit picks one 16 or 8-bit transfer
// RULE16: mode three master with direction and enable
// RULE17: mode two master with read and write
// RULE18: mode one addressed slave, 8-bit data
// RULE19: mode zero legacy slave, 8-bit data
// RULE20: setup wait one to four cycles
// RULE21: strobe wait one to sixteen cycles
// RULE22: hold wait per direction codes
// RULE23: zero strobe wait forces default setup, hold
// RULE24: select bits excluded from address stepping, except bit 15 under select function 11
// RULE25: data write or read starts a cycle
`timescale 1ns/1ps
module parallel_master_slave_port
    import pport_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // device state
    input wire logic device_idle,
    output logic port_irq,
    // parallel pins
    input wire logic [15:0] bus_data_pins_in,
    output logic [15:0] bus_data_pins_out,
    output logic [15:0] bus_data_pins_oe,
    input wire logic [1:0] bus_addr_pins_in,
    output logic [15:0] bus_addr_pins,
    output logic [15:0] bus_addr_pins_oe,
    output logic read_strobe_pin,
    output logic read_strobe_pin_oe,
    input wire logic read_strobe_pin_in,
    output logic write_strobe_pin,
    output logic write_strobe_pin_oe,
    input wire logic write_strobe_pin_in,
    input wire logic select_one_pin_in,
    output logic addr_latch_low_pin,
    output logic addr_latch_high_pin
);
    import pport_pkg::*;
    typedef struct packed {
        logic [15:0] ctl;
        logic [14:0] mode;
        logic [15:0] addr;
        logic [31:0] dout;
        logic [31:0] din;
        logic [15:0] pen;
        logic [7:0][7:0] buf_in;
        logic [3:0][7:0] buf_out;
        logic [3:0] in_full;
        logic [3:0] out_empty;
        logic obe;
        logic ovf;
        logic under;
        logic [1:0] rptr;
        logic [1:0] wptr;
        logic [31:0] rdata;
        logic irq;
        logic [15:0] dq;
        logic [2:0] slv_prev;
    } top_state_type;
    top_state_type s_r, s_nxt;
    pport_cfg_if cfg();
    pport_seq u_seq (
        .clk(clk),
        .rst(rst),
        .cfg(cfg.seq)
    );
    logic on, halted, master, wide;
    logic [1:0] mux, chip_select_function, irq_mode, addr_step_mode, pmode;
    logic slv_rd, slv_wr;
    logic [1:0] slv_idx;
    logic [15:0] stepped;
    always_comb
    begin
        on = s_r.ctl[ON_BIT];
        halted = !on || (s_r.ctl[IDLE_BIT] && device_idle); // RULE1 RULE2
        mux = s_r.ctl[MUX_LSB +: 2];
        chip_select_function = s_r.ctl[CSF_LSB +: 2];
        irq_mode = s_r.mode[IRQ_MODE_LSB +: 2];
        addr_step_mode = s_r.mode[ADDR_STEP_MODE_LSB +: 2];
        pmode = s_r.mode[PMODE_LSB +: 2];
        wide = s_r.mode[WIDE_BIT];
        master = pmode[1]; // RULE16 RULE17
        // external host strobes, chip select active high assumed
        slv_rd = !master && !halted && select_one_pin_in && read_strobe_pin_in && !s_r.slv_prev[0];
        slv_wr = !master && !halted && select_one_pin_in && write_strobe_pin_in && !s_r.slv_prev[1];
        if (pmode == 2'b01) // RULE18
            slv_idx = bus_addr_pins_in;
        else
            slv_idx = 2'b00; // RULE19
    end
    always_comb
    begin
        // keep select bits fixed for select functions 01 and 10; under 11 bit 15 still steps
        stepped = s_r.addr;
        if (addr_step_mode == 2'b01) // RULE13
            stepped = s_r.addr + 16'h0001;
        else if (addr_step_mode == 2'b10)
            stepped = s_r.addr - 16'h0001;
        if (chip_select_function == 2'b10) // RULE24
            stepped[15:14] = s_r.addr[15:14];
        else if (chip_select_function == 2'b01)
            stepped[15] = s_r.addr[15];
    end
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.slv_prev = {1'b0, write_strobe_pin_in, read_strobe_pin_in};
        s_nxt.irq = 1'b0;
        cfg.start = 1'b0;
        cfg.is_write = 1'b0;
        cfg.strobe_wait = s_r.mode[STROBE_LSB +: 4];
        cfg.setup_wait = s_r.mode[SETUP_LSB +: 2];
        cfg.hold_wait = s_r.mode[HOLD_LSB +: 2];
        cfg.mux_addr = (mux != 2'b00); // RULE3
        s_nxt.rdata = 32'h0000_0000;
        if (reg_wr)
        begin
            if (reg_addr == OFF_CONTROL)
                s_nxt.ctl = reg_wdata[15:0] & CONTROL_MASK;
            else if (reg_addr == OFF_MODE)
                s_nxt.mode = reg_wdata[14:0] & MODE_MASK[14:0];
            else if (reg_addr == OFF_ADDRESS)
                s_nxt.addr = reg_wdata[15:0];
            else if (reg_addr == OFF_DATA_OUT)
            begin
                s_nxt.dout = reg_wdata;
                if (master)
                begin
                    cfg.start = !halted && !cfg.busy; // RULE25 RULE1
                    cfg.is_write = 1'b1;
                end
                else
                begin
                    s_nxt.buf_out = reg_wdata;
                    s_nxt.out_empty = 4'h0;
                    s_nxt.obe = 1'b0;
                end
            end
            else if (reg_addr == OFF_DATA_IN)
                s_nxt.din = reg_wdata;
            else if (reg_addr == OFF_PIN_ENABLE)
                s_nxt.pen = reg_wdata[15:0];
            else if (reg_addr == OFF_STATUS)
            begin
                s_nxt.ovf = reg_wdata[14];
                s_nxt.under = reg_wdata[6];
            end
        end
        if (reg_rd)
        begin
            if (reg_addr == OFF_CONTROL)
                s_nxt.rdata = {16'h0000, s_r.ctl};
            else if (reg_addr == OFF_MODE)
                s_nxt.rdata = {16'h0000, cfg.busy, s_r.mode}; // RULE10
            else if (reg_addr == OFF_ADDRESS)
                s_nxt.rdata = {16'h0000, s_r.addr};
            else if (reg_addr == OFF_DATA_OUT)
                s_nxt.rdata = s_r.dout;
            else if (reg_addr == OFF_DATA_IN)
            begin
                if (master)
                begin
                    s_nxt.rdata = s_r.din;
                    cfg.start = !halted && !cfg.busy; // RULE25
                end
                else
                begin
                    s_nxt.rdata = {s_r.buf_in[3], s_r.buf_in[2], s_r.buf_in[1], s_r.buf_in[0]};
                    s_nxt.in_full = 4'h0;
                end
            end
            else if (reg_addr == OFF_PIN_ENABLE)
                s_nxt.rdata = {16'h0000, s_r.pen};
            else if (reg_addr == OFF_STATUS)
                s_nxt.rdata = {16'h0000, &s_r.in_full, s_r.ovf, 2'b00, s_r.in_full,
                    s_r.obe, s_r.under, 2'b00, s_r.out_empty};
        end
        // master cycle: capture during strobe, step address and interrupt at cycle end
        // read data follows the pins while the strobe is active
        if (cfg.phase[1] && !s_r.slv_prev[2])
            s_nxt.din = wide ? {16'h0000, bus_data_pins_in} : {24'h00_0000, bus_data_pins_in[7:0]}; // RULE15
        if (cfg.done)
        begin
            s_nxt.addr = stepped; // RULE13
            s_nxt.irq = (irq_mode == 2'b01); // RULE11
        end
        if (cfg.start)
            s_nxt.slv_prev[2] = cfg.is_write;
        else
            s_nxt.slv_prev[2] = s_r.slv_prev[2];
        // slave accesses from the external host
        if (slv_wr)
        begin
            s_nxt.buf_in[slv_idx] = bus_data_pins_in[7:0];
            if (s_r.in_full[slv_idx])
                s_nxt.ovf = 1'b1; // set wins over clear
            s_nxt.in_full[slv_idx] = 1'b1;
            if (addr_step_mode == 2'b11 && pmode == 2'b00) // RULE14
                s_nxt.wptr = s_r.wptr + 2'b01;
            s_nxt.irq = (irq_mode == 2'b01) || (irq_mode == 2'b10 && slv_idx == 2'b11); // RULE11 RULE12
        end
        if (slv_rd)
        begin
            if (s_r.out_empty[slv_idx])
                s_nxt.under = 1'b1;
            s_nxt.out_empty[slv_idx] = 1'b1;
            s_nxt.obe = &s_nxt.out_empty;
            if (addr_step_mode == 2'b11 && pmode == 2'b00) // RULE14
                s_nxt.rptr = s_r.rptr + 2'b01;
            s_nxt.irq = (irq_mode == 2'b01) || (irq_mode == 2'b10 && slv_idx == 2'b11); // RULE12
        end
        // slave read data driven on pins
        s_nxt.dq = {8'h00, s_r.buf_out[slv_idx]};
        if (master)
        begin
            s_nxt.dq = wide ? s_r.dout[15:0] : {8'h00, s_r.dout[7:0]}; // RULE15
            if (cfg.phase[2])
            begin
                if (mux == 2'b10)
                    s_nxt.dq = s_r.addr; // RULE3
                else if (mux == 2'b11)
                    s_nxt.dq = {8'h00, s_r.addr[7:0]};
                else if (mux == 2'b01)
                    s_nxt.dq = {s_nxt.dq[15:8], s_r.addr[7:0]};
            end
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.in_full <= 4'h0;
            s_r.out_empty <= STATUS_RESET[3:0];
            s_r.obe <= STATUS_RESET[7];
        end
        else
            s_r <= s_nxt;
    end
    // pin drive
    logic act, phase_a, strobe, is_wr, al_lvl;
    logic cs1_act, cs2_act;
    always_comb
    begin
        act = cfg.busy && master && on; // RULE1
        phase_a = cfg.phase[2];
        strobe = cfg.phase[1];
        is_wr = s_r.slv_prev[2];
        al_lvl = s_r.ctl[ALP_BIT]; // RULE7
        cs2_act = chip_select_function[1] || chip_select_function[0];
        cs1_act = (chip_select_function == 2'b10); // RULE6
        bus_data_pins_out = s_r.dq;
        bus_data_pins_oe = 16'h0000;
        if (act && (is_wr || phase_a))
            bus_data_pins_oe = (wide || phase_a) ? 16'hffff : 16'h00ff;
        else if (!master && on && slv_rd)
            bus_data_pins_oe = 16'h00ff;
        bus_addr_pins = s_r.addr;
        if (mux == 2'b01)
            bus_addr_pins[7:0] = s_r.addr[15:8];
        // selects replace address bits with polarity
        if (cs1_act) // RULE9
            bus_addr_pins[14] = act ? s_r.addr[14] ~^ s_r.ctl[SELECT_ONE_POLARITY_BIT] : !s_r.ctl[SELECT_ONE_POLARITY_BIT]; // RULE8
        if (cs2_act)
            bus_addr_pins[15] = act ? s_r.addr[15] ~^ s_r.ctl[SELECT_TWO_POLARITY_BIT] : !s_r.ctl[SELECT_TWO_POLARITY_BIT]; // RULE8
        bus_addr_pins_oe = (master && on) ? s_r.pen : 16'h0000;
        addr_latch_low_pin = (act && phase_a) ? al_lvl : !al_lvl; // RULE7
        addr_latch_high_pin = (act && phase_a && mux != 2'b11) ? al_lvl : !al_lvl;
        if (pmode == 2'b11) // RULE16
        begin
            read_strobe_pin = act ? !is_wr : 1'b1;
            write_strobe_pin = (act && strobe) ^ !s_r.ctl[WRSP_BIT];
        end
        else
        begin
            read_strobe_pin = (act && strobe && !is_wr) ^ !s_r.ctl[RDSP_BIT]; // RULE17
            write_strobe_pin = (act && strobe && is_wr) ^ !s_r.ctl[WRSP_BIT];
        end
        read_strobe_pin_oe = master && on && s_r.ctl[RDEN_BIT]; // RULE5
        write_strobe_pin_oe = master && on && s_r.ctl[WREN_BIT]; // RULE4
    end
    assign reg_rdata = s_r.rdata;
    assign port_irq = s_r.irq;

    chk_busy_start: assert property (@(posedge clk) disable iff (rst) // RULE25
        cfg.start |=> cfg.busy)
        else $error("no busy after start");
    chk_off_quiet: assert property (@(posedge clk) disable iff (rst) // RULE1
        !on |-> !act && read_strobe_pin_oe == 1'b0)
        else $error("access while disabled");
    chk_irq_end: assert property (@(posedge clk) disable iff (rst) // RULE11
        (cfg.done && irq_mode == 2'b01) |=> port_irq)
        else $error("missing cycle interrupt");
    chk_irq_none: assert property (@(posedge clk) disable iff (rst) // RULE11
        (irq_mode == 2'b00) |=> !port_irq)
        else $error("interrupt in mode zero");
    chk_step_up: assert property (@(posedge clk) disable iff (rst) // RULE13
        (cfg.done && addr_step_mode == 2'b01 && chip_select_function == 2'b00 && !reg_wr) |=> s_r.addr == $past(s_r.addr) + 16'h0001)
        else $error("address not incremented");
    chk_cs_fixed: assert property (@(posedge clk) disable iff (rst) // RULE24
        (cfg.done && chip_select_function == 2'b10 && !reg_wr) |=> s_r.addr[15:14] == $past(s_r.addr[15:14]))
        else $error("select bits stepped");
    chk_wr_pin_en: assert property (@(posedge clk) disable iff (rst) // RULE4
        !s_r.ctl[WREN_BIT] |-> !write_strobe_pin_oe)
        else $error("write pin driven while released");
    chk_halt_idle: assert property (@(posedge clk) disable iff (rst) // RULE2
        (s_r.ctl[IDLE_BIT] && device_idle) |-> !cfg.start)
        else $error("cycle started in idle");
endmodule

//--- tb/pport_peer.sv
// far-side peripheral model for the master modes of the parallel port
// assumes the bench decodes strobe activity and direction for it
`timescale 1ns/1ps
module pport_peer
(
    // clock
    input wire logic clk,
    // strobe seen by the peripheral
    input wire logic stb,
    input wire logic is_rd,
    // data pins
    input wire logic [15:0] data_out,
    output logic [15:0] data_in,
    output logic [15:0] last_wr
);
    parameter logic [15:0] RD_WORD = 16'h5a3c;
    logic flip = 1'b0;
    initial last_wr = 16'h0000;
    always @(posedge clk)
    begin
        flip <= ~flip;
        if (stb && !is_rd)
            last_wr <= data_out;
    end
    // released bus shows a toggling pattern, never a stale value
    assign data_in = (stb && is_rd) ? RD_WORD : (flip ? 16'h0f0f : 16'hf0f0);
endmodule

//--- tb/tb_parallel_master_slave_port.sv
// self-checking bench of the parallel port master modes and registers
// assumes the peer model file is compiled before this one
`timescale 1ns/1ps
module tb_parallel_master_slave_port;
    import pport_pkg::*;
    typedef struct {
        logic is_rd, wide;
        logic [1:0] pmode, b, e, addr_step_mode, irq_mode;
        logic [3:0] m;
        int stb, pre, post, irqs;
        logic [15:0] addr;
    } row_type;
    row_type rows[6] = '{
        '{0, 1, 2, 3, 3, 1, 1, 0, 1, 1, 1, 1, 16'h0001},
        '{0, 0, 2, 1, 2, 2, 0, 1, 2, 2, 3, 0, 16'hffff},
        '{0, 1, 2, 0, 0, 0, 1, 15, 16, 1, 1, 1, 16'h0000},
        '{1, 1, 2, 2, 1, 1, 1, 3, 4, 0, 0, 1, 16'h0001},
        '{1, 0, 2, 0, 0, 0, 0, 0, 1, 0, 0, 0, 16'h0000},
        '{0, 1, 3, 0, 1, 1, 1, 2, 3, 1, 2, 1, 16'h0001}};
    row_type cur;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, d;
    logic device_idle = 1'b0;
    logic port_irq, read_strobe_pin, write_strobe_pin, wr_idle, rd_idle, stb_on;
    logic [15:0] data_out, data_oe, data_in, peer_wr, oe_seen;
    int n_fail = 0;
    int num_checks = 0;
    int n_stb, n_pre, n_post, n_irq;
    logic [15:0] offs[8] = '{OFF_CONTROL, OFF_MODE, OFF_ADDRESS, OFF_DATA_OUT, OFF_DATA_IN,
        OFF_PIN_ENABLE, OFF_STATUS, 16'he070};

    always #2.5 clk = ~clk;

    parallel_master_slave_port dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .device_idle(device_idle),
        .port_irq(port_irq), .bus_data_pins_in(data_in), .bus_data_pins_out(data_out),
        .bus_data_pins_oe(data_oe), .bus_addr_pins_in(2'b00), .bus_addr_pins(), .bus_addr_pins_oe(),
        .read_strobe_pin(read_strobe_pin), .read_strobe_pin_oe(), .read_strobe_pin_in(1'b0),
        .write_strobe_pin(write_strobe_pin), .write_strobe_pin_oe(), .write_strobe_pin_in(1'b0),
        .select_one_pin_in(1'b0), .addr_latch_low_pin(), .addr_latch_high_pin());

    // strobe activity measured against the idle level, whatever the polarity
    assign stb_on = (cur.is_rd && cur.pmode == 2'd2) ? (read_strobe_pin !== rd_idle)
        : (write_strobe_pin !== wr_idle);

    pport_peer peer (.clk(clk), .stb(stb_on), .is_rd(cur.is_rd), .data_out(data_out),
        .data_in(data_in), .last_wr(peer_wr));

    always @(posedge clk)
    begin
        if (stb_on)
            n_stb++;
        else if (data_oe != 16'h0000)
        begin
            if (n_stb == 0)
                n_pre++;
            else
                n_post++;
        end
        if (data_oe != 16'h0000)
            oe_seen = data_oe;
        if (port_irq === 1'b1)
            n_irq++;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic wait_idle();
        logic [31:0] v;
        for (int k = 0; k < 100; k++)
        begin
            rd(OFF_MODE, v);
            if (v[BUSY_BIT] === 1'b0)
                return;
        end
        chk("idle", 1, 0);
    endtask

    task automatic go(input logic [31:0] c, input row_type r);
        cur = r;
        wr(OFF_CONTROL, c);
        wr(OFF_MODE, {16'h0, 1'b0, r.irq_mode, r.addr_step_mode, r.wide, r.pmode, r.b, r.m, r.e});
        wr(OFF_ADDRESS, 32'h0);
        wr(OFF_PIN_ENABLE, 32'h0000_ffff);
        repeat (2) @(posedge clk);
        wr_idle = write_strobe_pin;
        rd_idle = read_strobe_pin;
        @(negedge clk);
        n_stb = 0;
        n_pre = 0;
        n_post = 0;
        n_irq = 0;
        oe_seen = 16'h0000;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #100us;
        n_fail++;
        results();
    end

    initial
    begin
        cur = rows[0];
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            rd(offs[i], d);
            chk("reset value", d, (i == 6) ? 32'h0000_008e : 32'h0);
        end
        wr(OFF_ADDRESS, 32'hffff_ffff);
        rd(OFF_ADDRESS, d);
        chk("address rw", d, 32'h0000_ffff);
        wr(OFF_MODE, 32'hffff_ffff);
        rd(OFF_MODE, d);
        chk("busy read only", d, {16'h0, MODE_MASK});
        $display("register test done");
        for (int i = 0; i < 6; i++)
        begin
            go(32'h0000_8303, rows[i]);
            if (cur.is_rd)
                rd(OFF_DATA_IN, d);
            else
                wr(OFF_DATA_OUT, 32'h1234_a5c3);
            if (cur.m >= 4'd3)
            begin
                rd(OFF_MODE, d);
                chk("busy", d[BUSY_BIT], 1);
            end
            wait_idle();
            chk("strobe", n_stb, cur.stb);
            chk("setup", n_pre, cur.pre);
            chk("hold", n_post, cur.post);
            chk("irq", n_irq, cur.irqs);
            chk("data oe", oe_seen, cur.is_rd ? 32'h0 : (cur.wide ? 32'hffff : 32'h00ff));
            rd(OFF_ADDRESS, d);
            chk("address", d, {16'h0, cur.addr});
            if (cur.is_rd)
            begin
                rd(OFF_DATA_IN, d);
                chk("read data", d, cur.wide ? 32'h5a3c : 32'h3c);
                wait_idle();
            end
            else
                chk("write data", cur.wide ? peer_wr : {8'h0, peer_wr[7:0]}, cur.wide ? 32'ha5c3 : 32'hc3);
            $display("row %0d done", i);
        end
        go(32'h0000_0303, rows[0]);
        wr(OFF_DATA_OUT, 32'h1);
        repeat (20) @(posedge clk);
        chk("disabled strobe", n_stb, 0);
        device_idle <= 1'b1;
        go(32'h0000_a303, rows[0]);
        wr(OFF_DATA_OUT, 32'h1);
        repeat (20) @(posedge clk);
        chk("idle halt strobe", n_stb, 0);
        go(32'h0000_8303, rows[0]);
        wr(OFF_DATA_OUT, 32'h1);
        wait_idle();
        chk("idle run strobe", n_stb, 1);
        device_idle <= 1'b0;
        $display("enable test done");
        go(32'h0000_8383, rows[0]);
        wr(OFF_ADDRESS, 32'h0000_bfff);
        wr(OFF_DATA_OUT, 32'h1);
        wait_idle();
        rd(OFF_ADDRESS, d);
        chk("select bits kept", d, 32'h0000_8000);
        $display("select step test done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_CONTROL, d);
        chk("control after reset", d, 32'h0);
        rd(OFF_STATUS, d);
        chk("status after reset", d, 32'h0000_008e);
        $display("second reset test done");
        results();
    end
endmodule
